//--- hw/gated_sixteen_bit_timer.sv
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "gated_timer_regs.svh"
// What this block does
// - 16-bit counter, byte writes replace count bytes
// - Select bit clear: instruction clock, oscillator/4
// - External: pin, or low-power oscillator when allowed
// - Counter mode advances on input rising edge
// - Falling edge needed before first counted rise
// - Prescaler divides by one, two, four, eight
// - Prescaler hidden, cleared by count byte writes
// - Oscillator enable starts oscillator, runs in sleep
// - Oscillator on forces shared pins to input
// - Sync disable skips the extra sync stage, counts in sleep
// - Mode switch may lose or add a count
// - Byte reads always return coherent values
// - Gate enable: count only while gate active
// - Gate invert flips gate polarity for both sources
// - All-ones wraps to zero, sets overflow flag
// - Interrupt needs timer on and three enables
// - Sleep: only asynchronous external counting, overflow wakes
// - Count is capture time base and compare reference
// - Special event clears count without overflow flag
// - Count write beats a simultaneous special clear
module gated_sixteen_bit_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and outside sources, asynchronous
  input wire logic count_input_pin,
  input wire logic low_power_crystal_osc,
  input wire logic gate_input_pin,
  input wire logic comparator_two_output,
  // System state, same clock
  input wire logic osc_mode_allows_lp,
  input wire logic sleep_mode,
  input wire logic capture_event,
  input wire logic special_event,
  // Outputs
  output logic lp_osc_run,
  output logic pin5_direction,
  output logic pin4_direction,
  output logic [15:0] timer_count,
  output logic compare_match,
  output logic irq_request,
  output logic wake_request
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q; // Control register
  logic [15:0] count_q; // Running count
  logic [15:0] count_d;
  logic [2:0] presc_q; // Hidden prescale counter
  logic [2:0] presc_d;
  logic [1:0] div4_q; // Instruction clock divider
  logic flag_q; // Overflow flag
  logic irq_en_q; // Overflow interrupt enable
  logic [1:0] irq_ctrl_q; // Global and peripheral enables
  logic [15:0] capt_q; // Capture / compare pair
  logic gate_sel_q; // Gate source select
  logic [1:0] dir_q; // Software direction bits, pin5 and pin4
  logic [3:0] sync1_q; // First synchroniser stage
  logic [3:0] sync2_q; // Second synchroniser stage
  logic ext_prev_q; // Previous external level
  logic armed_q; // Falling edge seen since last restart
  logic rise_dly_q; // Extra stage of the synchronous path
  logic [31:0] prdata_q;
  logic match_q;
  logic wake_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite;
  wire wr_ctrl = wr & (paddr == `OFS_CTRL);
  wire wr_lo = wr & (paddr == `OFS_COUNT_LO);
  wire wr_hi = wr & (paddr == `OFS_COUNT_HI);
  wire wr_flag = wr & (paddr == `OFS_FLAG);
  wire wr_ien = wr & (paddr == `OFS_IRQ_EN);
  wire wr_ictl = wr & (paddr == `OFS_IRQ_CTRL);
  wire wr_clo = wr & (paddr == `OFS_CMP_LO);
  wire wr_chi = wr & (paddr == `OFS_CMP_HI);
  wire wr_cfg = wr & (paddr == `OFS_CFG);
  wire wr_pins = wr & (paddr == `OFS_PINS);
  wire wr_cnt = wr_lo | wr_hi;
  wire hit = (paddr == `OFS_CTRL) | (paddr == `OFS_COUNT_LO) | (paddr == `OFS_COUNT_HI) |
    (paddr == `OFS_FLAG) | (paddr == `OFS_IRQ_EN) | (paddr == `OFS_IRQ_CTRL) |
    (paddr == `OFS_CMP_LO) | (paddr == `OFS_CMP_HI) | (paddr == `OFS_CFG) |
    (paddr == `OFS_PINS);

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  wire timer_on = ctrl_q[`B_TIMER_ON];
  wire clock_source_select = ctrl_q[`B_CLK_SRC];
  wire sync_disable = ctrl_q[`B_SYNC_DIS];
  wire lp_osc_enable = ctrl_q[`B_OSC_EN];
  wire gate_enable = ctrl_q[`B_GATE_EN];
  wire gate_invert = ctrl_q[`B_GATE_INV];
  wire gated_timer_pkg::prescale_t prescale_select =
    gated_timer_pkg::prescale_t'(ctrl_q[`B_PS_HI:`B_PS_LO]);
  // Oscillator only usable in the allowed system clock modes
  wire osc_on = lp_osc_enable & osc_mode_allows_lp;

  // ----------------------------------------------------------------
  // Clock source and edge qualification
  // ----------------------------------------------------------------
  // Choose the external source after synchronising both
  wire ext_src = osc_on ? sync2_q[1] : sync2_q[0];
  wire ext_fall = ext_prev_q & ~ext_src;
  wire ext_rise = ext_src & ~ext_prev_q & armed_q;
  // Async path skips the extra stage, so switching may lose or gain one edge
  wire ext_tick = sync_disable ? ext_rise : rise_dly_q;
  wire int_tick = (div4_q == `INSTR_DIV_LAST);
  wire src_tick = clock_source_select ? ext_tick : int_tick;

  // ----------------------------------------------------------------
  // Gate and run condition
  // ----------------------------------------------------------------
  wire gated_timer_pkg::gate_src_t gate_timer_src = gated_timer_pkg::gate_src_t'(gate_sel_q);
  wire gate_raw = (gate_timer_src == gated_timer_pkg::GATE_CMP) ? sync2_q[3] : sync2_q[2];
  // Pin gate is active low unless inverted
  wire gate_active = gate_invert ? gate_raw : ~gate_raw;
  wire gate_ok = ~gate_enable | gate_active;
  // In sleep only the asynchronous external path keeps going
  wire sleep_ok = ~sleep_mode | (clock_source_select & sync_disable);
  wire run = timer_on & gate_ok & sleep_ok;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  wire [2:0] presc_last = 3'((4'h1 << prescale_select) - 4'h1);
  wire presc_step = run & src_tick;
  wire tick = presc_step & (presc_q == presc_last);

  always_comb begin
    // Write clears, stopped timer holds
    presc_d = presc_q;
    if (wr_cnt) begin
      presc_d = 3'h0;
    end else if (presc_step) begin
      presc_d = tick ? 3'h0 : presc_q + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  wire sp_clear = special_event & ~wr_cnt;
  wire overflow = tick & ~wr_cnt & ~special_event & (count_q == `COUNT_MAX);

  always_comb begin
    // Byte writes win, then the special clear, then the increment
    count_d = count_q;
    if (wr_cnt) begin
      if (wr_lo) begin
        count_d[7:0] = pwdata[7:0];
      end
      if (wr_hi) begin
        count_d[15:8] = pwdata[7:0];
      end
    end else if (sp_clear) begin
      count_d = `COUNT_RST;
    end else if (tick) begin
      count_d = count_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request and pin view
  // ----------------------------------------------------------------
  assign irq_request = flag_q & timer_on & irq_en_q & irq_ctrl_q[1] & irq_ctrl_q[0];
  assign lp_osc_run = osc_on;
  assign pin5_direction = dir_q[1] | osc_on;
  assign pin4_direction = dir_q[0] | osc_on;
  // Port bits of the shared pins read zero while the oscillator owns them
  wire [1:0] port_bits = osc_on ? 2'h0 : {sync2_q[1], sync2_q[0]};

  // ----------------------------------------------------------------
  // Read mux, every register a stable flop so bytes read coherent
  // ----------------------------------------------------------------
  wire [31:0] rd_mux =
    (paddr == `OFS_CTRL) ? {24'h0, ctrl_q} :
    (paddr == `OFS_COUNT_LO) ? {24'h0, count_q[7:0]} :
    (paddr == `OFS_COUNT_HI) ? {24'h0, count_q[15:8]} :
    (paddr == `OFS_FLAG) ? {31'h0, flag_q} :
    (paddr == `OFS_IRQ_EN) ? {31'h0, irq_en_q} :
    (paddr == `OFS_IRQ_CTRL) ? {24'h0, irq_ctrl_q, 6'h0} :
    (paddr == `OFS_CMP_LO) ? {24'h0, capt_q[7:0]} :
    (paddr == `OFS_CMP_HI) ? {24'h0, capt_q[15:8]} :
    (paddr == `OFS_CFG) ? {31'h0, gate_sel_q} :
    (paddr == `OFS_PINS) ? {26'h0, pin5_direction, pin4_direction, 2'h0, port_bits} :
    32'h0;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = prdata_q;
  assign timer_count = count_q;
  assign compare_match = match_q;
  assign wake_request = wake_q;

  // ----------------------------------------------------------------
  // Synchronisers; first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {comparator_two_output, gate_input_pin, low_power_crystal_osc, count_input_pin};
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Edge tracking; restart needs a fresh falling edge
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_q <= 1'b0;
      armed_q <= 1'b0;
      rise_dly_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_src;
      rise_dly_q <= ext_rise;
      if (wr_cnt | ~timer_on) begin
        armed_q <= 1'b0;
      end else if (ext_fall) begin
        armed_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counting core
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div4_q <= 2'h0;
      presc_q <= 3'h0;
      count_q <= `COUNT_RST;
      match_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      div4_q <= div4_q + 2'h1;
      presc_q <= presc_d;
      count_q <= count_d;
      match_q <= (capt_q == count_q);
      wake_q <= overflow & sleep_mode;
    end
  end

  // ----------------------------------------------------------------
  // Software registers; hardware set beats software clear
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RST;
      flag_q <= 1'b0;
      irq_en_q <= 1'b0;
      irq_ctrl_q <= 2'h0;
      capt_q <= `COUNT_RST;
      gate_sel_q <= 1'b0;
      dir_q <= `DIR_RST;
      prdata_q <= 32'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata[7:0];
      end
      if (overflow) begin
        flag_q <= 1'b1;
      end else if (wr_flag) begin
        flag_q <= pwdata[0];
      end
      if (wr_ien) begin
        irq_en_q <= pwdata[0];
      end
      if (wr_ictl) begin
        irq_ctrl_q <= pwdata[`B_GLOBAL_EN:`B_PERIPH_EN];
      end
      // Capture snapshot beats a software write of the pair
      if (capture_event) begin
        capt_q <= count_q;
      end else begin
        if (wr_clo) begin
          capt_q[7:0] <= pwdata[7:0];
        end
        if (wr_chi) begin
          capt_q[15:8] <= pwdata[7:0];
        end
      end
      if (wr_cfg) begin
        gate_sel_q <= pwdata[0];
      end
      if (wr_pins) begin
        dir_q <= {pwdata[`B_PIN5], pwdata[`B_PIN4]};
      end
      if (setup) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_sync_rise;
    ext_rise && !sync_disable;
  endsequence
  sequence s_wrap;
    tick && !wr_cnt && !special_event && count_q == 16'hffff;
  endsequence

  a_low_write: assert property (wr_lo |=> count_q[7:0] == $past(pwdata[7:0]))
    else $error("low byte write lost");
  a_presc_clear: assert property (wr_cnt |=> presc_q == 3'h0)
    else $error("prescaler not cleared by count write");
  a_wrap_flag: assert property (s_wrap |=> count_q == 16'h0000 && flag_q)
    else $error("wrap did not set flag");
  a_stop_hold: assert property (!timer_on && !wr_cnt && !special_event
    |=> $stable(count_q) && $stable(presc_q) && !$rose(flag_q))
    else $error("stopped timer moved");
  a_special_clr: assert property (special_event && !wr_cnt && !flag_q
    |=> count_q == 16'h0000 && !flag_q)
    else $error("special clear wrong");
  a_write_wins: assert property (wr_hi && special_event
    |=> count_q[15:8] == $past(pwdata[7:0]))
    else $error("special clear beat write");
  a_osc_pins: assert property (osc_on |-> pin5_direction && pin4_direction && port_bits == 2'h0)
    else $error("shared pins not forced");
  a_sync_delay: assert property (s_sync_rise ##1 (clock_source_select && !sync_disable)
    |-> ext_tick)
    else $error("synchronous edge not counted one cycle later");
  a_sleep_stop: assert property (sleep_mode && !(clock_source_select && sync_disable)
    |=> $stable(count_q) || $past(wr_cnt) || $past(special_event))
    else $error("counting in sleep without async source");
  a_irq_cond: assert property (irq_request |-> flag_q && timer_on && irq_en_q && irq_ctrl_q == 2'h3)
    else $error("interrupt without enables");

endmodule

//--- hw/gated_timer_regs.svh
`ifndef GATED_TIMER_REGS_SVH
`define GATED_TIMER_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 12'h000
`define OFS_COUNT_LO 12'h004
`define OFS_COUNT_HI 12'h008
`define OFS_FLAG 12'h00c
`define OFS_IRQ_EN 12'h010
`define OFS_IRQ_CTRL 12'h014
`define OFS_CMP_LO 12'h018
`define OFS_CMP_HI 12'h01c
`define OFS_CFG 12'h020
`define OFS_PINS 12'h024

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define B_TIMER_ON 0
`define B_CLK_SRC 1
`define B_SYNC_DIS 2
`define B_OSC_EN 3
`define B_PS_LO 4
`define B_PS_HI 5
`define B_GATE_EN 6
`define B_GATE_INV 7

// ----------------------------------------------------------------
// Other fields
// ----------------------------------------------------------------
`define B_GLOBAL_EN 7
`define B_PERIPH_EN 6
`define B_PIN4 4
`define B_PIN5 5

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define CTRL_RST 8'h00
`define COUNT_RST 16'h0000
`define COUNT_MAX 16'hffff
`define DIR_RST 2'h3
`define INSTR_DIV_LAST 2'h3

`endif

//--- hw/gated_timer_pkg.sv
package gated_timer_pkg;
  // Prescale ratio of the selected clock
  typedef enum logic [1:0] {
    PS_1 = 2'h0,
    PS_2 = 2'h1,
    PS_4 = 2'h2,
    PS_8 = 2'h3
  } prescale_t;
  // Source of the count-enable gate
  typedef enum logic {
    GATE_PIN = 1'h0,
    GATE_CMP = 1'h1
  } gate_src_t;
endpackage

//--- bench/ext_source_model.sv
`timescale 1ns/1ns
module ext_source_model #(
  parameter int OSC_HALF = 4
) (
  // Clock and oscillator request
  input wire logic pclk,
  input wire logic lp_osc_run,
  // Pins driven into the timer
  output logic count_input_pin,
  output logic low_power_crystal_osc,
  output logic gate_input_pin,
  output logic comparator_two_output
);
  int osc_cnt; // Half-period counter of the crystal

  initial begin
    count_input_pin = 1'b0;
    low_power_crystal_osc = 1'b0;
    gate_input_pin = 1'b1;
    comparator_two_output = 1'b1;
    osc_cnt = 0;
  end

  // Crystal stands low until enabled, so no stray edge leaks in
  always @(posedge pclk) begin
    if (lp_osc_run !== 1'b1) begin
      low_power_crystal_osc <= 1'b0;
      osc_cnt <= 0;
    end else if (osc_cnt == OSC_HALF - 1) begin
      low_power_crystal_osc <= ~low_power_crystal_osc;
      osc_cnt <= 0;
    end else begin
      osc_cnt <= osc_cnt + 1;
    end
  end

  // Comparator level, owned here so the bench never drives the net itself
  task automatic set_cmp(input logic v);
    comparator_two_output <= v;
  endtask

  // Full pulses, widths random but wide enough for the synchronizer
  task automatic pulses(input int n);
    int w;
    repeat (n) begin
      w = 2 + int'($urandom % 4);
      count_input_pin <= 1'b1;
      repeat (w) @(posedge pclk);
      count_input_pin <= 1'b0;
      repeat (w) @(posedge pclk);
    end
  endtask
endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ns
`include "gated_timer_regs.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("Error %0t: got %h expected %h", $time, a, b); end end
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic cin, osc, gin, cmp, allow_lp, sleep_mode, capture_event, special_event;
  logic lp_osc_run, pin5_direction, pin4_direction, compare_match, irq_request, wake_request;
  logic [15:0] timer_count;
  logic se_arm, woke;
  logic [32:0] exp_q[$]; // Expected {pslverr, prdata} per read
  logic [32:0] e;
  int n_errors = 0;
  int n_checks = 0;

  gated_sixteen_bit_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_input_pin(cin), .low_power_crystal_osc(osc),
    .gate_input_pin(gin), .comparator_two_output(cmp), .osc_mode_allows_lp(allow_lp),
    .sleep_mode(sleep_mode), .capture_event(capture_event), .special_event(special_event),
    .lp_osc_run(lp_osc_run), .pin5_direction(pin5_direction), .pin4_direction(pin4_direction),
    .timer_count(timer_count), .compare_match(compare_match), .irq_request(irq_request),
    .wake_request(wake_request));
  ext_source_model i_src (.pclk(pclk), .lp_osc_run(lp_osc_run), .count_input_pin(cin),
    .low_power_crystal_osc(osc), .gate_input_pin(gin), .comparator_two_output(cmp));

  // ----------------------------------------
  // Clock, verdict, watchdog
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic give_verdict;
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Whole run is far below this; a hang ends here
  initial begin
    #3000000;
    n_errors++;
    give_verdict();
  end

  // ----------------------------------------
  // APB master and read monitor
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     input logic [32:0] ex);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    if (!wr) exp_q.push_back(ex);
    @(posedge pclk);
    penable <= 1'b1;
    special_event <= se_arm;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_errors++;
      give_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    special_event <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 33'h000000000);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] d);
    bus(1'b0, a, 8'h00, {9'h000, 24'h000000} | {25'h0000000, d});
  endtask

  // Completed reads are compared against the oldest note
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1ffffffff;
      `CHK({pslverr, prdata}, e)
    end
  end

  // Wake pulse lasts one cycle, so it is latched here
  always @(posedge pclk) if (wake_request === 1'b1) woke <= 1'b1;

  // Count advance over a window, after the pipeline has settled
  task automatic rate(input int cyc, input logic [15:0] d);
    logic [15:0] a;
    repeat (12) @(posedge pclk);
    a = timer_count;
    repeat (cyc) @(posedge pclk);
    `CHK(16'(timer_count - a), d)
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic [15:0] v;
    int n;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {allow_lp, sleep_mode, capture_event, special_event, se_arm, woke} = '0;
    presetn = 1'b0;
    void'($urandom(32'h9a38));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`OFS_CTRL, `CTRL_RST);
    `CHK({pin5_direction, pin4_direction}, `DIR_RST)
    bus(1'b0, 12'h040, 8'h00, {1'b1, 32'h00000000});
    // Random count bytes; timer stopped while writing
    v = 16'($urandom);
    wr(`OFS_COUNT_LO, v[7:0]);
    wr(`OFS_COUNT_HI, v[15:8]);
    rd(`OFS_COUNT_LO, v[7:0]);
    rd(`OFS_COUNT_HI, v[15:8]);
    for (int p = 0; p < 4; p++) begin
      wr(`OFS_CTRL, 8'h00);
      wr(`OFS_COUNT_LO, 8'h00);
      wr(`OFS_CTRL, 8'(8'h01 | (p << 4)));
      rate(32 << p, 16'h0008);
    end
    // Wrap, flag and interrupt enables
    wr(`OFS_CTRL, 8'h00);
    wr(`OFS_COUNT_LO, 8'hfe);
    wr(`OFS_COUNT_HI, 8'hff);
    wr(`OFS_CTRL, 8'h01);
    n = 0;
    while (timer_count !== `COUNT_RST && n < 300) begin
      @(posedge pclk);
      n++;
    end
    `CHK(n < 300, 1'b1)
    if (n >= 300) give_verdict();
    `CHK(woke, 1'b0)
    rd(`OFS_FLAG, 8'h01);
    wr(`OFS_IRQ_EN, 8'h01);
    wr(`OFS_IRQ_CTRL, 8'hc0);
    `CHK(irq_request, 1'b1)
    wr(`OFS_IRQ_CTRL, 8'h80);
    `CHK(irq_request, 1'b0)
    wr(`OFS_FLAG, 8'h00);
    // Special clear, and a write that meets it
    wr(`OFS_CTRL, 8'h00);
    wr(`OFS_COUNT_HI, 8'h12);
    special_event <= 1'b1;
    @(posedge pclk);
    special_event <= 1'b0;
    @(posedge pclk);
    `CHK(timer_count, 16'h0000)
    rd(`OFS_FLAG, 8'h00);
    wr(`OFS_COUNT_HI, 8'h12);
    se_arm = 1'b1;
    wr(`OFS_COUNT_LO, 8'h56);
    se_arm = 1'b0;
    `CHK(timer_count, 16'h1256)
    capture_event <= 1'b1;
    @(posedge pclk);
    capture_event <= 1'b0;
    rd(`OFS_CMP_LO, 8'h56);
    rd(`OFS_CMP_HI, 8'h12);
    `CHK(compare_match, 1'b1)
    // Gate from pin (active low) and from comparator
    wr(`OFS_CTRL, 8'h41);
    rate(40, 16'h0000);
    wr(`OFS_CTRL, 8'hc1);
    rate(32, 16'h0008);
    wr(`OFS_CFG, 8'h01);
    wr(`OFS_CTRL, 8'h41);
    rate(40, 16'h0000);
    i_src.set_cmp(1'b0);
    rate(32, 16'h0008);
    // External pin: the first rise after a count write is not counted
    wr(`OFS_CTRL, 8'h00);
    wr(`OFS_COUNT_LO, 8'h00);
    wr(`OFS_COUNT_HI, 8'h00);
    wr(`OFS_CTRL, 8'h03);
    i_src.pulses(5);
    repeat (8) @(posedge pclk);
    `CHK(timer_count, 16'h0004)
    // Sleep: internal clock holds, asynchronous pin counts and wakes
    wr(`OFS_CTRL, 8'h01);
    sleep_mode <= 1'b1;
    rate(40, 16'h0000);
    wr(`OFS_CTRL, 8'h00);
    wr(`OFS_COUNT_LO, 8'hff);
    wr(`OFS_COUNT_HI, 8'hff);
    wr(`OFS_CTRL, 8'h07);
    i_src.pulses(2);
    repeat (8) @(posedge pclk);
    `CHK(timer_count, 16'h0000)
    `CHK(woke, 1'b1)
    sleep_mode <= 1'b0;
    // Oscillator: shared pins forced, then used as source after start-up
    wr(`OFS_CTRL, 8'h00);
    wr(`OFS_PINS, 8'h00);
    `CHK(pin5_direction, 1'b0)
    wr(`OFS_CTRL, 8'h08);
    `CHK(lp_osc_run, 1'b0)
    allow_lp <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK(lp_osc_run, 1'b1)
    `CHK(pin4_direction, 1'b1)
    rd(`OFS_PINS, 8'h30);
    repeat (50) @(posedge pclk);
    wr(`OFS_CTRL, 8'h0b);
    rate(64, 16'h0008);
    give_verdict();
  end
endmodule
